// >>> rtl/dbp_ctrl.sv
// Controller end: makes the link clock, spaces commands, moves bursts
// What this block does
// R1: Read and write command encodings
// R2: Bursts always run to completion
// R3: Read-to-write spacing with strobe skew
// R4: Seamless reads every fourth clock
// R5: Column from CA5r-CA6r and CA1f-CA9f
// R6: Write data WL clocks after command
// R7: Strobe preamble then eight data beats
// R8: Write-to-read spacing
// R9: tWTR counts after last write beat
// R10: Seamless writes every fourth clock
// R11: Byte mask line per beat
// R12: Precharge command encoding
// R13: All-bank flag or bank select
// R14: Reopen after tRPab or tRPpb
// R15: Read-to-precharge spacing with tRTP
// R16: tRAS before precharge, tRP before activate
// R17: Write-to-precharge spacing with tWR
// R18: Write recovery from group boundary
// R19: Auto-precharge bit closes bank
// R20: No auto-precharge keeps bank open
// R21: Read auto-precharge start point
// R22: Reactivate after tRP and tRC
// R23: Track banks, refuse illegal commands
`default_nettype none
module dbp_ctrl
  import dbp_pkg::*;
#(
  parameter int SLOTS = 4
)(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  dbp_link.ctrl link,
  input wire logic i_req_valid,
  input wire dbp_kind_t i_req_kind,
  input wire logic [BANK_W-1:0] i_req_bank,
  input wire logic [10:0] i_req_col,
  input wire logic [CA_W-1:0] i_req_row,
  input wire logic i_req_ap,
  input wire logic i_req_all,
  input wire logic [BURST_W-1:0] i_wdata,
  input wire logic [BL-1:0] i_wmask,
  output logic o_req_ready,
  output logic [BURST_W-1:0] o_rdata,
  output logic o_rvalid
);
  localparam int DIV_W = $clog2(CK_HALF);
  localparam int PTR_W = $clog2(SLOTS);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CK_HALF - 1);
  localparam logic [DIV_W-1:0] DIV_READY = DIV_W'(CK_HALF - 2);

  logic [DIV_W-1:0] div;
  logic ck;
  logic edge_now;
  logic rise_ev;
  logic fall_ev;
  logic take;
  logic legal;
  logic [NBANK-1:0] open;
  dbp_cnt_t act_wait [NBANK];
  dbp_cnt_t pre_wait [NBANK];
  dbp_cnt_t rw_wait [NBANK];
  dbp_cnt_t rd_wait;
  dbp_cnt_t wr_wait;
  logic all_pre_ok;
  logic [BURST_W-1:0] wbuf [SLOTS];
  logic [BL-1:0] mbuf [SLOTS];
  logic [SLOTS-1:0] w_vld;
  dbp_cnt_t w_cnt [SLOTS];
  logic [PTR_W-1:0] w_ptr;
  logic [SLOTS-1:0] r_vld;
  dbp_cnt_t r_cnt [SLOTS];
  logic [PTR_W-1:0] r_ptr;
  logic w_hit;
  logic w_pre;
  logic [DW2-1:0] w_data;
  logic [DMW-1:0] w_mask;
  logic r_hit;
  logic r_last;
  logic [BEAT_W-1:0] r_beat;
  logic [PTR_W-1:0] r_slot;
  logic [DW2-1:0] dq_s;
  logic [BURST_W-1:0] racc;

  // Link clock from a divider; no second domain here
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      div <= '0;
      ck <= 1'b0;
    end
    else
    begin
      div <= (div == DIV_LAST) ? '0 : div + 1'b1;
      if (div == DIV_LAST)
        ck <= ~ck;
    end
  end

  assign edge_now = div == DIV_LAST;
  assign rise_ev = edge_now && !ck;
  assign fall_ev = edge_now && ck;
  assign take = fall_ev && i_req_valid && o_req_ready;
  assign link.ck = ck;

  // Read data passes two flops before use
  dbp_sync #(.W(DW2)) u_dq_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_d(link.dq),
    .o_q(dq_s)
  );

  // Legality of the held request against the timers that its kind checks
  always_comb
  begin
    all_pre_ok = 1'b1;
    for (int b = 0; b < NBANK; b++)
    begin
      if (pre_wait[b] != '0)
        all_pre_ok = 1'b0;
    end
    case (i_req_kind)
      K_ACT: legal = !open[i_req_bank] && act_wait[i_req_bank] == '0; // R23
      K_RD: legal = open[i_req_bank] && rw_wait[i_req_bank] == '0 && rd_wait == '0; // R23
      K_WR: legal = open[i_req_bank] && rw_wait[i_req_bank] == '0 && wr_wait == '0; // R23
      K_PRE: legal = i_req_all ? all_pre_ok : pre_wait[i_req_bank] == '0; // R16
      default: legal = 1'b0;
    endcase
  end

  // Ready only in the cycle before a falling edge
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
      o_req_ready <= 1'b0;
    else
      o_req_ready <= div == DIV_READY && ck && i_req_valid && legal;
  end

  // Command pins change on the falling edge, stable at the rise
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      link.cs_n <= 1'b1;
      link.ca_r <= '0;
      link.ca_f <= '0;
    end
    else if (fall_ev)
    begin
      link.cs_n <= !take;
      link.ca_r <= '0;
      link.ca_f <= '0;
      if (take)
      begin
        case (i_req_kind)
          K_ACT:
          begin
            link.ca_r <= {i_req_bank, 5'h00, OPC_ACT};
            link.ca_f <= i_req_row;
          end
          K_RD:
          begin
            link.ca_r <= {i_req_bank, i_req_col[1:0], 2'h0, OPC_RD}; // R1 R5
            link.ca_f <= {i_req_col[10:2], i_req_ap}; // R19 R20
          end
          K_WR:
          begin
            link.ca_r <= {i_req_bank, i_req_col[1:0], 2'h0, OPC_WR}; // R1 R5
            link.ca_f <= {i_req_col[10:2], i_req_ap};
          end
          default:
            link.ca_r <= {i_req_bank, 2'h0, i_req_all, OPC_PRE}; // R12 R13
        endcase
      end
    end
  end

  // Bank state and spacing timers, in link clocks
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      open <= '0;
      rd_wait <= '0;
      wr_wait <= '0;
      for (int b = 0; b < NBANK; b++)
      begin
        act_wait[b] <= '0;
        pre_wait[b] <= '0;
        rw_wait[b] <= '0;
      end
    end
    else if (rise_ev)
    begin
      rd_wait <= cnt_dec(rd_wait);
      wr_wait <= cnt_dec(wr_wait);
      for (int b = 0; b < NBANK; b++)
      begin
        act_wait[b] <= cnt_dec(act_wait[b]);
        pre_wait[b] <= cnt_dec(pre_wait[b]);
        rw_wait[b] <= cnt_dec(rw_wait[b]);
      end
    end
    else if (take)
    begin
      case (i_req_kind)
        K_ACT:
        begin
          open[i_req_bank] <= 1'b1;
          pre_wait[i_req_bank] <= cnt_max(pre_wait[i_req_bank], RAS_CK); // R16
          act_wait[i_req_bank] <= RC_CK; // R22
          rw_wait[i_req_bank] <= RCD_CK;
        end
        K_RD:
        begin
          rd_wait <= cnt_max(rd_wait, CCD_CK); // R4
          wr_wait <= cnt_max(wr_wait, RD2WR_CK); // R3
          pre_wait[i_req_bank] <= cnt_max(pre_wait[i_req_bank], RD2PRE_CK); // R15
          if (i_req_ap)
          begin
            open[i_req_bank] <= 1'b0;
            act_wait[i_req_bank] <= cnt_max(act_wait[i_req_bank], RDAP_ACT_CK); // R21 R22
          end
        end
        K_WR:
        begin
          wr_wait <= cnt_max(wr_wait, CCD_CK); // R10
          rd_wait <= cnt_max(rd_wait, WR2RD_CK); // R8 R9
          pre_wait[i_req_bank] <= cnt_max(pre_wait[i_req_bank], WR2PRE_CK); // R17 R18
          if (i_req_ap)
          begin
            open[i_req_bank] <= 1'b0;
            act_wait[i_req_bank] <= cnt_max(act_wait[i_req_bank], WRAP_ACT_CK); // R22
          end
        end
        default:
        begin
          for (int b = 0; b < NBANK; b++)
          begin
            if (i_req_all || i_req_bank == BANK_W'(b))
            begin
              open[b] <= 1'b0;
              act_wait[b] <= cnt_max(act_wait[b], i_req_all ? RPAB_CK : RPPB_CK); // R14
            end
          end
        end
      endcase
    end
  end

  // Find the write beat or preamble due at this falling edge
  always_comb
  begin
    w_hit = 1'b0;
    w_pre = 1'b0;
    w_data = '0;
    w_mask = '0;
    for (int s = 0; s < SLOTS; s++)
    begin
      if (w_vld[s] && w_cnt[s] != '0 && w_cnt[s] <= CLKS_CK)
      begin
        w_hit = 1'b1;
        w_data = wbuf[s][DW2 * int'(CLKS_CK - w_cnt[s]) +: DW2];
        w_mask = mbuf[s][DMW * int'(CLKS_CK - w_cnt[s]) +: DMW];
      end
      if (w_vld[s] && w_cnt[s] == PREAMBLE_CK)
        w_pre = 1'b1;
    end
  end

  // Find the read beat the device is driving now
  always_comb
  begin
    r_hit = 1'b0;
    r_last = 1'b0;
    r_beat = '0;
    r_slot = '0;
    for (int s = 0; s < SLOTS; s++)
    begin
      if (r_vld[s] && r_cnt[s] < CLKS_CK)
      begin
        r_hit = 1'b1;
        r_last = r_cnt[s] == '0;
        r_beat = BEAT_W'(CLKS_CK - 1'b1 - r_cnt[s]);
        r_slot = PTR_W'(s);
      end
    end
  end

  // Burst slots; several overlap when bursts are seamless
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      w_vld <= '0;
      r_vld <= '0;
      w_ptr <= '0;
      r_ptr <= '0;
      for (int s = 0; s < SLOTS; s++)
      begin
        w_cnt[s] <= '0;
        r_cnt[s] <= '0;
        wbuf[s] <= '0;
        mbuf[s] <= '0;
      end
    end
    else if (rise_ev)
    begin
      for (int s = 0; s < SLOTS; s++)
      begin
        if (w_cnt[s] == dbp_cnt_t'(1))
          w_vld[s] <= 1'b0; // R2
        w_cnt[s] <= cnt_dec(w_cnt[s]);
        r_cnt[s] <= cnt_dec(r_cnt[s]);
      end
    end
    else if (fall_ev)
    begin
      if (r_hit && r_last)
        r_vld[r_slot] <= 1'b0; // R2
      if (take && i_req_kind == K_WR)
      begin
        w_vld[w_ptr] <= 1'b1;
        w_cnt[w_ptr] <= CTL_WR_CK; // R6
        wbuf[w_ptr] <= i_wdata;
        mbuf[w_ptr] <= i_wmask;
        w_ptr <= w_ptr + 1'b1;
      end
      if (take && i_req_kind == K_RD)
      begin
        r_vld[r_ptr] <= 1'b1;
        r_cnt[r_ptr] <= CTL_RD_CK;
        r_ptr <= r_ptr + 1'b1;
      end
    end
  end

  // Write pins: strobe preamble, then beats with their mask
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      link.dq_c <= '0;
      link.dq_c_oe <= 1'b0;
      link.dqs_c <= 1'b0;
      link.dqs_c_oe <= 1'b0;
      link.dm <= '0;
    end
    else if (fall_ev)
    begin
      link.dq_c <= w_data;
      link.dq_c_oe <= w_hit;
      link.dqs_c <= w_hit; // R7
      link.dqs_c_oe <= w_hit || w_pre; // R7
      link.dm <= w_mask; // R11
    end
  end

  // Read assembly; beat pair 0 lands in the low bits
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      racc <= '0;
      o_rdata <= '0;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= fall_ev && r_hit && r_last;
      if (fall_ev && r_hit)
        racc[DW2 * int'(r_beat) +: DW2] <= dq_s;
      if (fall_ev && r_hit && r_last)
        o_rdata <= {dq_s, racc[BURST_W-DW2-1:0]};
    end
  end
endmodule : dbp_ctrl
`default_nettype wire

// >>> rtl/dbp_link.sv
// Link between controller and SDRAM, with two-way pin resolution
`default_nettype none
interface dbp_link;
  import dbp_pkg::*;
  logic ck;
  logic cs_n;
  logic [CA_W-1:0] ca_r;
  logic [CA_W-1:0] ca_f;
  logic [DW2-1:0] dq_c;
  logic dq_c_oe;
  logic [DW2-1:0] dq_d;
  logic dq_d_oe;
  logic [DW2-1:0] dq;
  logic dqs_c;
  logic dqs_c_oe;
  logic dqs_d;
  logic dqs_d_oe;
  logic dqs;
  logic [DMW-1:0] dm;

  // Undriven wire reads as zero
  assign dq = dq_c_oe ? dq_c : (dq_d_oe ? dq_d : '0);
  assign dqs = dqs_c_oe ? dqs_c : (dqs_d_oe ? dqs_d : 1'b0);

  modport ctrl (output ck, cs_n, ca_r, ca_f, dq_c, dq_c_oe, dqs_c, dqs_c_oe, dm, input dq, dqs);
  modport dev (input ck, cs_n, ca_r, ca_f, dq, dqs, dm, output dq_d, dq_d_oe, dqs_d, dqs_d_oe);
endinterface : dbp_link
`default_nettype wire

// >>> rtl/dbp_pkg.sv
// Shared constants, types and helpers for the burst/precharge link
`default_nettype none
package dbp_pkg;
  // Clocking
  localparam int SYS_CLK_NS = 10;
  localparam int CK_HALF = 4; // System cycles per link half period
  localparam int TCK_NS = 2 * CK_HALF * SYS_CLK_NS;
  // Geometry
  localparam int DW = 8;
  localparam int BEATS_PER_CK = 2;
  localparam int DW2 = BEATS_PER_CK * DW;
  localparam int DMW = DW2 / 8;
  localparam int BL = 8;
  localparam int CLKS = BL / 2;
  localparam int BEAT_W = $clog2(CLKS);
  localparam int BURST_W = BL * DW;
  localparam int NBANK = 8;
  localparam int BANK_W = 3;
  localparam int CA_W = 10;
  // Latencies (link clocks) and analog times (ns)
  localparam int RL = 12;
  localparam int WL = 6;
  localparam int T_DQSCK_MAX_NS = 6;
  localparam int T_WTR_NS = 8;
  localparam int T_WR_NS = 15;
  localparam int T_RTP_NS = 8;
  localparam int T_RPPB_NS = 18;
  localparam int T_RPAB_NS = 21;
  localparam int T_RAS_NS = 42;
  localparam int T_RC_NS = 63;
  localparam int T_RCD_NS = 18;
  // Command field positions and codes
  localparam logic [1:0] OPC_ACT = 2'h2;
  localparam logic [2:0] OPC_RD = 3'h5;
  localparam logic [2:0] OPC_WR = 3'h1;
  localparam logic [3:0] OPC_PRE = 4'hb;
  localparam int AB_BIT = 4;
  localparam int BANK_LSB = 7;
  localparam int AP_BIT = 0;
  localparam int COL_SEL_F = 2; // Falling bit that picks the burst row in storage

  localparam int CNT_W = 6;
  typedef logic [CNT_W-1:0] dbp_cnt_t;
  typedef enum logic [1:0] {K_ACT = 2'h0, K_RD = 2'h1, K_WR = 2'h2, K_PRE = 2'h3} dbp_kind_t;

  function automatic int ru(input int ns);
    return (ns + TCK_NS - 1) / TCK_NS;
  endfunction : ru

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax

  function automatic dbp_cnt_t cnt_dec(input dbp_cnt_t c);
    return (c == '0) ? c : c - 1'b1;
  endfunction : cnt_dec

  function automatic dbp_cnt_t cnt_max(input dbp_cnt_t a, input dbp_cnt_t b);
    return (a > b) ? a : b;
  endfunction : cnt_max

  // Link-clock spacings
  localparam dbp_cnt_t CCD_CK = dbp_cnt_t'(CLKS);
  localparam dbp_cnt_t RD2WR_CK = dbp_cnt_t'(RL + ru(T_DQSCK_MAX_NS) + CLKS + 1 - WL);
  localparam dbp_cnt_t WR2RD_CK = dbp_cnt_t'(WL + 1 + CLKS + ru(T_WTR_NS));
  localparam dbp_cnt_t RD2PRE_CK = dbp_cnt_t'(CLKS + imax(4, ru(T_RTP_NS)) - 4);
  localparam dbp_cnt_t WR2PRE_CK = dbp_cnt_t'(WL + CLKS + 1 + ru(T_WR_NS));
  localparam dbp_cnt_t RPPB_CK = dbp_cnt_t'(ru(T_RPPB_NS));
  localparam dbp_cnt_t RPAB_CK = dbp_cnt_t'(ru(T_RPAB_NS));
  localparam dbp_cnt_t RAS_CK = dbp_cnt_t'(ru(T_RAS_NS));
  localparam dbp_cnt_t RC_CK = dbp_cnt_t'(ru(T_RC_NS));
  localparam dbp_cnt_t RCD_CK = dbp_cnt_t'(ru(T_RCD_NS));
  localparam dbp_cnt_t RDAP_ACT_CK = dbp_cnt_t'(RD2PRE_CK + RPPB_CK);
  localparam dbp_cnt_t WRAP_ACT_CK = dbp_cnt_t'(WR2PRE_CK + RPPB_CK);
  // Burst slot counts
  localparam dbp_cnt_t CLKS_CK = dbp_cnt_t'(CLKS);
  localparam dbp_cnt_t PREAMBLE_CK = dbp_cnt_t'(CLKS + 1);
  localparam dbp_cnt_t DEV_RD_CK = dbp_cnt_t'(RL + CLKS - 1);
  localparam dbp_cnt_t DEV_WR_CK = dbp_cnt_t'(WL + CLKS - 1);
  localparam dbp_cnt_t CTL_RD_CK = dbp_cnt_t'(RL + CLKS);
  localparam dbp_cnt_t CTL_WR_CK = dbp_cnt_t'(WL + CLKS);
endpackage : dbp_pkg
`default_nettype wire

// >>> rtl/dbp_sdram.sv
// Device end: command decode, burst data path, bank open state
`default_nettype none
module dbp_sdram
  import dbp_pkg::*;
#(
  parameter int SLOTS = 4,
  parameter int MEM_WORDS = 64
)(
  dbp_link.dev link,
  input wire logic i_reset,
  output logic [NBANK-1:0] o_bank_open,
  output logic o_burst_active
);
  localparam int PTR_W = $clog2(SLOTS);
  localparam int IDX_W = $clog2(MEM_WORDS);

  logic [DW2-1:0] mem [MEM_WORDS];
  logic [SLOTS-1:0] s_vld;
  logic [SLOTS-1:0] s_wr;
  dbp_cnt_t s_cnt [SLOTS];
  logic [BANK_W-1:0] s_bank [SLOTS];
  logic [SLOTS-1:0] s_col;
  logic [PTR_W-1:0] s_ptr;
  dbp_cnt_t ap_cnt [NBANK];
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic [BANK_W-1:0] bank;
  logic hit;
  logic hit_wr;
  logic preamble;
  logic [IDX_W-1:0] hit_idx;

  // Command decode on the registering edge
  always_comb
  begin
    bank = link.ca_r[BANK_LSB +: BANK_W];
    is_act = !link.cs_n && link.ca_r[1:0] == OPC_ACT;
    is_rd = !link.cs_n && link.ca_r[2:0] == OPC_RD;
    is_wr = !link.cs_n && link.ca_r[2:0] == OPC_WR;
    is_pre = !link.cs_n && link.ca_r[3:0] == OPC_PRE; // R12
  end

  // Which slot owns the current data clock
  always_comb
  begin
    hit = 1'b0;
    hit_wr = 1'b0;
    preamble = 1'b0;
    hit_idx = '0;
    for (int s = 0; s < SLOTS; s++)
    begin
      if (s_vld[s] && s_cnt[s] != '0 && s_cnt[s] <= CLKS_CK)
      begin
        hit = 1'b1;
        hit_wr = s_wr[s];
        hit_idx = IDX_W'({s_bank[s], s_col[s], BEAT_W'(CLKS_CK - s_cnt[s])});
      end
      if (s_vld[s] && !s_wr[s] && s_cnt[s] == PREAMBLE_CK)
        preamble = 1'b1;
    end
  end

  // Burst slots; a started burst always runs out
  always_ff @(posedge link.ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      s_vld <= '0;
      s_wr <= '0;
      s_col <= '0;
      s_ptr <= '0;
      for (int s = 0; s < SLOTS; s++)
      begin
        s_cnt[s] <= '0;
        s_bank[s] <= '0;
      end
    end
    else
    begin
      for (int s = 0; s < SLOTS; s++)
      begin
        if (s_vld[s] && s_cnt[s] == dbp_cnt_t'(1))
          s_vld[s] <= 1'b0; // R2
        s_cnt[s] <= cnt_dec(s_cnt[s]);
      end
      // Seamless bursts reuse the next slot every fourth clock
      if (is_rd || is_wr)
      begin
        s_vld[s_ptr] <= 1'b1; // R4 R10
        s_wr[s_ptr] <= is_wr;
        s_cnt[s_ptr] <= is_rd ? DEV_RD_CK : DEV_WR_CK;
        s_bank[s_ptr] <= bank;
        s_col[s_ptr] <= link.ca_f[COL_SEL_F]; // R5
        s_ptr <= s_ptr + 1'b1;
      end
    end
  end

  // Read drive with one clock of strobe preamble
  always_ff @(posedge link.ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      link.dq_d <= '0;
      link.dq_d_oe <= 1'b0;
      link.dqs_d <= 1'b0;
      link.dqs_d_oe <= 1'b0;
    end
    else
    begin
      link.dq_d <= (hit && !hit_wr) ? mem[hit_idx] : '0;
      link.dq_d_oe <= hit && !hit_wr;
      link.dqs_d <= hit && !hit_wr;
      link.dqs_d_oe <= (hit && !hit_wr) || preamble;
    end
  end

  // Write capture; masked bytes keep their old value
  always_ff @(posedge link.ck)
  begin
    if (hit && hit_wr && link.dqs)
    begin
      for (int b = 0; b < DMW; b++)
      begin
        if (!link.dm[b])
          mem[hit_idx][b*8 +: 8] <= link.dq[b*8 +: 8]; // R11
      end
    end
  end

  // Bank state: activate, precharge and auto-precharge
  always_ff @(posedge link.ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_bank_open <= '0;
      for (int b = 0; b < NBANK; b++)
        ap_cnt[b] <= '0;
    end
    else
    begin
      for (int b = 0; b < NBANK; b++)
      begin
        if (ap_cnt[b] == dbp_cnt_t'(1))
          o_bank_open[b] <= 1'b0; // R19
        ap_cnt[b] <= cnt_dec(ap_cnt[b]);
      end
      if (is_act)
        o_bank_open[bank] <= 1'b1;
      if (is_pre)
      begin
        for (int b = 0; b < NBANK; b++)
        begin
          if (link.ca_r[AB_BIT] || bank == BANK_W'(b))
            o_bank_open[b] <= 1'b0; // R13
        end
      end
      // Write recovery counts from the end of the full 8-beat group
      if ((is_rd || is_wr) && link.ca_f[AP_BIT])
        ap_cnt[bank] <= is_rd ? RD2PRE_CK : WR2PRE_CK; // R21 R18
      // Without auto-precharge the bank simply stays open (R20)
    end
  end

  always_ff @(posedge link.ck or posedge i_reset)
  begin
    if (i_reset)
      o_burst_active <= 1'b0;
    else
      o_burst_active <= |s_vld;
  end
endmodule : dbp_sdram
`default_nettype wire

// >>> rtl/dbp_sync.sv
// Two flip-flop synchroniser for pin inputs
`default_nettype none
module dbp_sync #(
  parameter int W = 1
)(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      meta <= '0;
      o_q <= '0;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule : dbp_sync
`default_nettype wire

// >>> sim/dbp_chk.sv
// Link timing checker for the controller and SDRAM ends
`default_nettype none
module dbp_chk
  import dbp_pkg::*;
(
  input wire logic i_reset,
  input wire logic ck,
  input wire logic cs_n,
  input wire logic [CA_W-1:0] ca_r,
  input wire logic dq_c_oe,
  input wire logic dqs_c,
  input wire logic dqs_c_oe,
  input wire logic dq_d_oe,
  input wire logic dqs_d,
  input wire logic dqs_d_oe
);
  // Command decode as the device sees it
  logic rd;
  logic wr;
  logic pre;
  assign rd = !cs_n && ca_r[2:0] == 3'h5;
  assign wr = !cs_n && ca_r[2:0] == 3'h1;
  assign pre = !cs_n && ca_r[3:0] == 4'hb;

  // Eleven quiet rises, split since repeats stop at eight
  sequence s_no_wr11;
    (!wr) [*8] ##1 (!wr) [*3];
  endsequence
  sequence s_no_rd11;
    (!rd) [*8] ##1 (!rd) [*3];
  endsequence
  sequence s_wbeats;
    (dq_c_oe && dqs_c) [*4];
  endsequence
  sequence s_rbeats;
    (dq_d_oe && dqs_d) [*4];
  endsequence

  property p_rd_wr;
    @(posedge ck) disable iff (i_reset) rd |=> s_no_wr11;
  endproperty
  property p_wr_rd;
    @(posedge ck) disable iff (i_reset) wr |=> s_no_rd11;
  endproperty
  property p_ccd;
    @(posedge ck) disable iff (i_reset) (rd || wr) |=> (!(rd || wr)) [*3];
  endproperty
  property p_rd_pre;
    @(posedge ck) disable iff (i_reset) rd |=> (!pre) [*3];
  endproperty
  property p_wr_pre;
    @(posedge ck) disable iff (i_reset) wr |=> (!pre) [*8] ##1 (!pre) [*3];
  endproperty
  property p_wr_data;
    @(posedge ck) disable iff (i_reset) wr |-> ##5 dqs_c_oe ##1 s_wbeats;
  endproperty
  // Read data is taken at falls, so watch it there
  property p_rd_data;
    @(negedge ck) disable iff (i_reset) rd |-> ##11 dqs_d_oe ##1 s_rbeats;
  endproperty
  property p_no_clash;
    @(posedge ck) disable iff (i_reset) dq_c_oe |-> !dq_d_oe;
  endproperty

  a_rd_wr: assert property (p_rd_wr) else $error("write too soon after read");
  a_wr_rd: assert property (p_wr_rd) else $error("read too soon after write");
  a_ccd: assert property (p_ccd) else $error("bursts closer than four clocks");
  a_rd_pre: assert property (p_rd_pre) else $error("precharge too soon after read");
  a_wr_pre: assert property (p_wr_pre) else $error("precharge too soon after write");
  a_wr_data: assert property (p_wr_data) else $error("write strobe or beats misplaced");
  a_rd_data: assert property (p_rd_data) else $error("read burst cut or misplaced");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
endmodule : dbp_chk
`default_nettype wire

// >>> sim/test_dbp_burst_precharge_timing.sv
// Bench joining controller and SDRAM ends across the link
`default_nettype none
module test_dbp_burst_precharge_timing
  import dbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CKC = 2 * CK_HALF;
  // Strobe skew rounds to one clock at this rate
  localparam int RD2WR = RL + 1 + CLKS + 1 - WL;
  localparam int WR2RD = WL + 1 + CLKS + 1;
  localparam int WR2PRE = WL + CLKS + 1 + 1;
  localparam logic [63:0] DA = 64'h0123456789abcdef;
  localparam logic [63:0] DB = 64'hfedcba9876543210;
  localparam logic [63:0] DBM = 64'hfedcba987654cd10;
  localparam logic [63:0] DC = 64'h55aa33cc0ff0a5c3;
  logic i_clk_sys;
  logic i_reset;
  logic i_req_valid;
  dbp_kind_t i_req_kind;
  logic [BANK_W-1:0] i_req_bank;
  logic [10:0] i_req_col;
  logic [CA_W-1:0] i_req_row;
  logic i_req_ap;
  logic i_req_all;
  logic [BURST_W-1:0] i_wdata;
  logic [BL-1:0] i_wmask;
  logic o_req_ready;
  logic [BURST_W-1:0] o_rdata;
  logic o_rvalid;
  logic [NBANK-1:0] o_bank_open;
  logic o_burst_active;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int t_take;
  int t_wr;
  logic [BURST_W-1:0] rq[$];

  dbp_link dbp_link_inst ();
  dbp_ctrl dbp_ctrl_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(dbp_link_inst),
    .i_req_valid(i_req_valid), .i_req_kind(i_req_kind), .i_req_bank(i_req_bank), .i_req_col(i_req_col),
    .i_req_row(i_req_row), .i_req_ap(i_req_ap), .i_req_all(i_req_all), .i_wdata(i_wdata),
    .i_wmask(i_wmask), .o_req_ready(o_req_ready), .o_rdata(o_rdata), .o_rvalid(o_rvalid));
  dbp_sdram dbp_sdram_inst (.link(dbp_link_inst), .i_reset(i_reset), .o_bank_open(o_bank_open),
    .o_burst_active(o_burst_active));
  dbp_chk dbp_chk_inst (.i_reset(i_reset), .ck(dbp_link_inst.ck), .cs_n(dbp_link_inst.cs_n),
    .ca_r(dbp_link_inst.ca_r), .dq_c_oe(dbp_link_inst.dq_c_oe), .dqs_c(dbp_link_inst.dqs_c),
    .dqs_c_oe(dbp_link_inst.dqs_c_oe), .dq_d_oe(dbp_link_inst.dq_d_oe), .dqs_d(dbp_link_inst.dqs_d),
    .dqs_d_oe(dbp_link_inst.dqs_d_oe));

  always #5 i_clk_sys = ~i_clk_sys;

  // Read bursts may land while later requests wait
  always @(negedge i_clk_sys)
    if (o_rvalid === 1'b1)
      rq.push_back(o_rdata);

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // Cycle count, and a ceiling well past the full sequence
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Hold a request until ready, note the take edge
  task automatic req(input dbp_kind_t k, input logic [2:0] b, input logic [10:0] col,
      input logic [63:0] wd = '0, input logic [7:0] wm = '0, input logic ap = 1'b0, input logic all = 1'b0);
    int n;
    @(negedge i_clk_sys);
    i_req_valid = 1'b1;
    i_req_kind = k;
    i_req_bank = b;
    i_req_col = col;
    i_req_row = col[9:0];
    i_wdata = wd;
    i_wmask = wm;
    i_req_ap = ap;
    i_req_all = all;
    n = 0;
    do
    begin
      @(negedge i_clk_sys);
      n++;
    end
    while (o_req_ready !== 1'b1 && n < 400);
    chk("ready", 64'h1, 64'(n < 400));
    t_take = cyc + 1;
    @(negedge i_clk_sys);
    i_req_valid = 1'b0;
  endtask : req

  task automatic bank(input logic [7:0] exp);
    int n;
    n = 0;
    while (o_bank_open !== exp && n < 64)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    chk("bank open", 64'(exp), 64'(o_bank_open));
  endtask : bank

  // Seamless writes with a masked beat, seamless reads back
  task automatic t_burst();
    int t0;
    int n;
    req(K_ACT, 3'h1, 11'h3);
    req(K_WR, 3'h1, 11'h0, DA);
    t0 = t_take;
    req(K_WR, 3'h1, 11'h0, DB, 8'h02);
    chk("wr spacing", 64'(CLKS * CKC), 64'(t_take - t0));
    req(K_WR, 3'h1, 11'h8, DC);
    t0 = t_take;
    req(K_RD, 3'h1, 11'h0);
    chk("wr to rd", 64'h1, 64'(t_take - t0 >= WR2RD * CKC));
    t0 = t_take;
    req(K_RD, 3'h1, 11'h8);
    chk("rd spacing", 64'(CLKS * CKC), 64'(t_take - t0));
    t0 = t_take;
    req(K_WR, 3'h1, 11'h8, DA);
    chk("rd to wr", 64'h1, 64'(t_take - t0 >= RD2WR * CKC));
    t_wr = t_take;
    n = 0;
    while (rq.size() < 2 && n < 400)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    chk("read col 0", DBM, rq[0]);
    chk("read col 8", DC, rq[1]);
    $display("test burst done");
  endtask : t_burst

  // Single and all-bank precharge
  task automatic t_pre();
    req(K_PRE, 3'h1, 11'h0);
    chk("wr to pre", 64'h1, 64'(t_take - t_wr >= WR2PRE * CKC));
    bank(8'h00);
    req(K_ACT, 3'h2, 11'h5);
    req(K_ACT, 3'h3, 11'h6);
    bank(8'h0c);
    req(K_PRE, 3'h3, 11'h0);
    bank(8'h04);
    req(K_ACT, 3'h3, 11'h6);
    req(K_PRE, 3'h3, 11'h0, '0, '0, 1'b0, 1'b1);
    bank(8'h00);
    $display("test precharge done");
  endtask : t_pre

  // Auto-precharge closes the bank at the stated clock
  task automatic ap_case(input dbp_kind_t k, input int shut, input int reopen);
    int t0;
    req(k, 3'h4, 11'h0, '0, '0, 1'b1);
    t0 = t_take;
    repeat (shut * CKC + 3) @(negedge i_clk_sys);
    chk("open before ap", 64'h1, 64'(o_bank_open[4]));
    repeat (1) @(negedge i_clk_sys);
    chk("shut after ap", 64'h0, 64'(o_bank_open[4]));
    req(K_ACT, 3'h4, 11'h7);
    chk("ap to act", 64'h1, 64'(t_take - t0 >= reopen * CKC));
  endtask : ap_case

  task automatic t_ap();
    req(K_ACT, 3'h4, 11'h7);
    req(K_RD, 3'h4, 11'h0);
    repeat (6 * CKC) @(negedge i_clk_sys);
    chk("open after plain rd", 64'h1, 64'(o_bank_open[4]));
    chk("burst busy", 64'h1, 64'(o_burst_active));
    ap_case(K_RD, 4, 5);
    ap_case(K_WR, 12, 13);
    chk("burst idle", 64'h0, 64'(o_burst_active));
    $display("test auto precharge done");
  endtask : t_ap

  initial
  begin
    i_clk_sys = 1'b0;
    i_reset = 1'b1;
    i_req_valid = 1'b0;
    i_req_kind = K_ACT;
    i_req_bank = '0;
    i_req_col = '0;
    i_req_row = '0;
    i_req_ap = 1'b0;
    i_req_all = 1'b0;
    i_wdata = '0;
    i_wmask = '0;
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_reset = 1'b0;
    t_burst();
    t_pre();
    t_ap();
    test_done();
  end
endmodule : test_dbp_burst_precharge_timing
`default_nettype wire
